// ### include/fsa_consts.svh
// Constants of the frame synchronizer: register offsets, field ranges,
// reset values and pattern lengths. Included by the frame synchronizer top only.
`ifndef FSA_CONSTS_SVH
`define FSA_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define FSA_ADDR_CTRL 5'h00
`define FSA_ADDR_THR 5'h04
`define FSA_ADDR_STATUS 5'h08
`define FSA_ADDR_MASK 5'h0c
`define FSA_ADDR_STATE 5'h10

// ==========================================================================
// Fields and reset values
`define FSA_CTRL_EN 0
`define FSA_THR_TS 7:0
`define FSA_THR_TC 15:8
`define FSA_THR_LS 23:16
`define FSA_THR_LC 31:24
`define FSA_THR_RESET 32'ha65ce19c
`define FSA_EV_LOCK 0
`define FSA_EV_LOSS 1
`define FSA_EV_PRESYNC 2
`define FSA_EV_FRAME 3

// ==========================================================================
// Pattern lengths
`define FSA_LINE_LEN 89
`define FSA_SOF_TAPS 25
`define FSA_PLS_LEN 64
`define FSA_CW_DIFFS 63
`define FSA_ALL_TAPS 57

`endif

// ### include/fsa_pkg.sv
// Types shared by the frame synchronizer files.
// Assumes nothing of its surroundings.
package fsa_pkg;

  // ========================================================================
  // Acquisition states
  typedef enum logic [1:0] {
    FSA_UNLOCKED,
    FSA_TENTATIVE,
    FSA_LOCKED
  } fsa_state_t;

endpackage

// ### hw/fsa_phasor_corr.sv
// Unit-phasor correlator: sums received phases rotated by reference phases.
// Assumes phases are 2-bit indices of powers of i from the same clock.
`timescale 1ns/10ps
`default_nettype none

module fsa_phasor_corr #(
  parameter int N = 25
) (
  // Phases in
  input wire logic [N-1:0][1:0] i_rx,
  input wire logic [N-1:0][1:0] i_ref,
  input wire logic [N-1:0] i_use,
  // Complex sum out
  output logic signed [7:0] o_re,
  output logic signed [7:0] o_im
);

  // ========================================================================
  // Multiplying by a conjugate tap is a phase subtraction, so no multiplier.
  always_comb begin
    o_re = 8'sd0;
    o_im = 8'sd0;
    for (int k = 0; k < N; k++) begin
      if (i_use[k]) begin
        case (2'(i_rx[k] - i_ref[k]))
          2'h0: o_re = o_re + 8'sd1;
          2'h1: o_im = o_im + 8'sd1;
          2'h2: o_re = o_re - 8'sd1;
          default: o_im = o_im - 8'sd1;
        endcase
      end
    end
  end

endmodule // fsa_phasor_corr
`default_nettype wire

// ### hw/fsa_frame_sync.sv
// Frame synchronizer: differential correlator and acquisition state machine.
// Assumes symbols arrive timing-locked, one per i_sym_valid, on i_mclk.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "fsa_consts.svh"

module fsa_frame_sync #(
  parameter int SYM_W = 8,
  parameter int CNT_W = 17,
  parameter logic [2*`FSA_SOF_TAPS-1:0] SOF_REF = '0,
  parameter logic [2*`FSA_PLS_LEN-1:0] PLS_REF = '0,
  parameter logic [`FSA_PLS_LEN-1:0] PLS_MASK = 64'h5555555555555555,
  parameter logic [`FSA_PLS_LEN-1:0] SCRAMBLE = '0
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Symbol stream
  input wire logic i_sym_valid,
  input wire logic signed [SYM_W-1:0] i_sym_i,
  input wire logic signed [SYM_W-1:0] i_sym_q,
  // Frame length in symbols of the decided codeword
  input wire logic [CNT_W-1:0] i_frame_len,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Frame results
  output logic o_locked,
  output logic o_frame_start,
  output logic [6:0] o_code_idx,
  output logic [15:0] o_corr_pow,
  output logic o_irq
);

  // ========================================================================
  // State
  typedef struct packed {
    fsa_pkg::fsa_state_t st;
    logic en;
    logic [31:0] thr;
    logic [3:0] status;
    logic [3:0] mask;
    logic [1:0] prev_q;
    logic [`FSA_LINE_LEN-1:0][1:0] dline;
    logic chk;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] frame_len;
    logic srch;
    logic [6:0] cand;
    logic [6:0] best_idx;
    logic [15:0] best_pow;
    logic [6:0] code_idx;
    logic [`FSA_CW_DIFFS-1:0][1:0] cw;
    logic [15:0] corr_pow;
    logic frame_pulse;
    logic [31:0] rdata;
  } fsa_regs_t;

  fsa_regs_t r;
  fsa_regs_t n;

  // ========================================================================
  // Helpers
  // Squared magnitude; both parts are widened first so the square cannot wrap.
  function automatic logic [31:0] fsa_pow(
    input logic signed [8:0] re,
    input logic signed [8:0] im
  );
    logic signed [31:0] a;
    logic signed [31:0] b;
    a = 32'(re);
    b = 32'(im);
    return 32'(a * a + b * b);
  endfunction

  // Power against (t/256 * full)^2, so thresholds are fractions of one.
  function automatic logic fsa_over(
    input logic [31:0] pw,
    input logic [7:0] t,
    input logic [6:0] full
  );
    logic [47:0] lhs;
    logic [47:0] lim;
    // An 8-bit threshold times a 7-bit length, squared, stays far below 48 bits.
    lhs = {pw, 16'h0000};
    lim = 48'(t) * 48'(full);
    lim = 48'(lim * lim);
    return lhs > lim;
  endfunction

  // Phase index of codeword symbol n; odd symbols carry a quarter turn.
  function automatic logic [1:0] fsa_cw_ph(
    input logic [6:0] k,
    input logic [5:0] pos
  );
    logic b;
    b = (^(k[6:1] & pos)) ^ k[0] ^ SCRAMBLE[pos];
    return 2'({b, 1'b0} + {1'b0, pos[0]});
  endfunction

  // ========================================================================
  // Correlators
  logic signed [7:0] sof_re;
  logic signed [7:0] sof_im;
  logic signed [7:0] pls_re;
  logic signed [7:0] pls_im;
  logic signed [7:0] cw_re;
  logic signed [7:0] cw_im;
  logic [`FSA_CW_DIFFS-1:0][1:0] cw_ref;

  // The start section holds the oldest 25 differentials of the line.
  fsa_phasor_corr #(
    .N(`FSA_SOF_TAPS)
  ) u_sof (
    .i_rx(r.dline[`FSA_LINE_LEN-1:`FSA_PLS_LEN]),
    .i_ref(SOF_REF),
    .i_use({`FSA_SOF_TAPS{1'b1}}),
    .o_re(sof_re),
    .o_im(sof_im)
  );

  fsa_phasor_corr #(
    .N(`FSA_PLS_LEN)
  ) u_pls (
    .i_rx(r.dline[`FSA_PLS_LEN-1:0]),
    .i_ref(PLS_REF),
    .i_use(PLS_MASK),
    .o_re(pls_re),
    .o_im(pls_im)
  );

  // One codeword candidate per clock over the frozen codeword snapshot.
  fsa_phasor_corr #(
    .N(`FSA_CW_DIFFS)
  ) u_cw (
    .i_rx(r.cw),
    .i_ref(cw_ref),
    .i_use({`FSA_CW_DIFFS{1'b1}}),
    .o_re(cw_re),
    .o_im(cw_im)
  );

  // Entry j of the snapshot holds the step into codeword symbol 63-j.
  always_comb begin
    for (int j = 0; j < `FSA_CW_DIFFS; j++) begin
      cw_ref[j] = 2'(fsa_cw_ph(r.cand, 6'(63 - j)) - fsa_cw_ph(r.cand, 6'(62 - j)));
    end
  end

  // ========================================================================
  // Metrics
  logic [31:0] sof_pw;
  logic [31:0] sum_pw;
  logic [31:0] dif_pw;
  logic [31:0] comb_pw;
  logic [31:0] cw_pw;
  logic [1:0] quad;

  always_comb begin
    sof_pw = fsa_pow(9'(sof_re), 9'(sof_im));
    sum_pw = fsa_pow(9'(sof_re) + 9'(pls_re), 9'(sof_im) + 9'(pls_im));
    dif_pw = fsa_pow(9'(sof_re) - 9'(pls_re), 9'(sof_im) - 9'(pls_im));
    comb_pw = (sum_pw > dif_pw) ? sum_pw : dif_pw;
    cw_pw = fsa_pow(9'(cw_re), 9'(cw_im));
    // Hard quadrant decision; arbitrary carrier phase cancels in the step.
    // Only the sign bits are read, since a QPSK header carries no magnitude.
    case ({i_sym_i[SYM_W-1], i_sym_q[SYM_W-1]})
      2'b00: quad = 2'h0;
      2'b10: quad = 2'h1;
      2'b11: quad = 2'h2;
      default: quad = 2'h3;
    endcase
  end

  // ========================================================================
  // Next state
  logic [3:0] ev;
  logic start;
  logic last;
  logic [15:0] fin_pow;
  logic [7:0] fin_thr;

  always_comb begin
    n = r;
    ev = 4'h0;
    start = 1'b0;
    last = 1'b0;
    fin_pow = 16'h0000;
    fin_thr = 8'h00;
    n.chk = 1'b0;
    n.frame_pulse = 1'b0;

    if (i_wr) begin
      case (i_addr)
        `FSA_ADDR_CTRL: n.en = i_wdata[`FSA_CTRL_EN];
        `FSA_ADDR_THR: n.thr = i_wdata;
        `FSA_ADDR_MASK: n.mask = i_wdata[3:0];
        default: ;
      endcase
    end

    // Read data stand only in the cycle after the strobe and are zero otherwise.
    n.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `FSA_ADDR_CTRL: n.rdata = {31'h0, r.en};
        `FSA_ADDR_THR: n.rdata = r.thr;
        `FSA_ADDR_STATUS: n.rdata = {28'h0, r.status};
        `FSA_ADDR_MASK: n.rdata = {28'h0, r.mask};
        `FSA_ADDR_STATE: n.rdata = {14'h0, r.code_idx, 8'h0, r.srch, r.st};
        default: n.rdata = 32'h0000_0000;
      endcase
    end

    // Symbol intake: one differential per symbol enters the line.
    // Unlocked checks every position; locked checks only where a header ends.
    if (i_sym_valid) begin
      n.prev_q = quad;
      n.dline = {r.dline[`FSA_LINE_LEN-2:0], 2'(quad - r.prev_q)};
      if (r.st == fsa_pkg::FSA_UNLOCKED) begin
        n.cnt = '0;
        n.chk = 1'b1;
      end else if (r.st == fsa_pkg::FSA_LOCKED && CNT_W'(r.cnt + 1'b1) == r.frame_len) begin
        n.cnt = '0;
        n.chk = 1'b1;
      end else begin
        n.cnt = CNT_W'(r.cnt + 1'b1);
      end
    end

    // A check sees the line one cycle after the symbol that completed it.
    // A locked check that falls inside a running search is skipped, so frames
    // shorter than one search plus one check are not supported.
    if (r.chk) begin
      n.corr_pow = comb_pw[15:0];
      if (fsa_over(comb_pw, r.thr[`FSA_THR_TS], 7'(`FSA_ALL_TAPS))) begin
        ev[`FSA_EV_PRESYNC] = 1'b1;
      end
      case (r.st)
        fsa_pkg::FSA_UNLOCKED: begin
          if (fsa_over(sof_pw, r.thr[`FSA_THR_TS], 7'(`FSA_SOF_TAPS))) begin
            n.st = fsa_pkg::FSA_TENTATIVE;
            start = 1'b1;
          end
        end
        fsa_pkg::FSA_LOCKED: begin
          if (!r.srch) begin
            if (fsa_over(sof_pw, r.thr[`FSA_THR_LS], 7'(`FSA_SOF_TAPS))) begin
              start = 1'b1;
            end else begin
              n.st = fsa_pkg::FSA_UNLOCKED;
              ev[`FSA_EV_LOSS] = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    // Codeword search: 128 candidates, one per clock, best one kept.
    if (r.srch) begin
      if (r.cand == 7'h00 || cw_pw[15:0] > r.best_pow) begin
        n.best_pow = cw_pw[15:0];
        n.best_idx = r.cand;
      end
      n.cand = 7'(r.cand + 1'b1);
      last = (r.cand == 7'h7f);
    end

    // A search cut short by a disable decides nothing, so a parked machine
    // never reports a frame. The length is sampled per decision, so every
    // frame may carry its own length.
    if (last && r.en) begin
      n.srch = 1'b0;
      fin_pow = n.best_pow;
      fin_thr = (r.st == fsa_pkg::FSA_TENTATIVE) ? r.thr[`FSA_THR_TC] : r.thr[`FSA_THR_LC];
      if (fsa_over({16'h0, fin_pow}, fin_thr, 7'(`FSA_CW_DIFFS))) begin
        n.st = fsa_pkg::FSA_LOCKED;
        n.code_idx = n.best_idx;
        n.frame_len = i_frame_len;
        n.frame_pulse = 1'b1;
        ev[`FSA_EV_FRAME] = 1'b1;
        ev[`FSA_EV_LOCK] = (r.st == fsa_pkg::FSA_TENTATIVE);
      end else begin
        n.st = fsa_pkg::FSA_UNLOCKED;
        ev[`FSA_EV_LOSS] = (r.st == fsa_pkg::FSA_LOCKED);
      end
    end

    // Snapshot the 63 codeword steps so the line may keep shifting.
    if (start) begin
      n.srch = 1'b1;
      n.cand = 7'h00;
      n.best_pow = 16'h0000;
      n.cw = r.dline[`FSA_CW_DIFFS-1:0];
      n.cnt = i_sym_valid ? CNT_W'(1) : '0;
    end

    // Disable parks the machine; a running search is abandoned.
    if (!r.en) begin
      n.st = fsa_pkg::FSA_UNLOCKED;
      n.srch = 1'b0;
    end

    // New events win over a clear written in the same cycle.
    n.status = r.status;
    if (i_wr && i_addr == `FSA_ADDR_STATUS) begin
      n.status = r.status & ~i_wdata[3:0];
    end
    n.status = n.status | ev;
  end

  // ========================================================================
  // Registers
  // Enable and thresholds come up at their defaults, so the hunt starts at once.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
      r.st <= fsa_pkg::FSA_UNLOCKED;
      r.en <= 1'b1;
      r.thr <= `FSA_THR_RESET;
    end else begin
      r <= n;
    end
  end

  // ========================================================================
  // Outputs
  assign o_rdata = r.rdata;
  assign o_locked = (r.st == fsa_pkg::FSA_LOCKED);
  assign o_frame_start = r.frame_pulse;
  assign o_code_idx = r.code_idx;
  assign o_corr_pow = r.corr_pow;
  // The interrupt is a level; it falls only when software clears or masks it.
  assign o_irq = |(r.status & r.mask);

endmodule // fsa_frame_sync
`default_nettype wire

// ### test/fsa_frame_sync_sva.sv
// Port checker for the frame synchronizer top.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module fsa_frame_sync_sva (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Frame results
  input wire logic o_locked,
  input wire logic o_frame_start,
  input wire logic [6:0] o_code_idx,
  input wire logic [15:0] o_corr_pow,
  input wire logic o_irq
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  // ==========================================================================
  // Cycles since the last accepted frame; saturates so it never wraps.
  logic [7:0] gap;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gap <= 8'hff;
    end else if (o_frame_start) begin
      gap <= 8'h00;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end

  // ==========================================================================
  // Properties
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its answer cycle");
  pulse_short_a: assert property (o_frame_start |=> !o_frame_start)
    else $error("frame start longer than one cycle");
  start_locked_a: assert property (o_frame_start |-> o_locked)
    else $error("frame accepted while not locked");
  lock_entry_a: assert property ($rose(o_locked) |-> o_frame_start)
    else $error("lock without an accepted frame");
  search_time_a: assert property ($rose(o_locked) |-> !$past(o_locked, 129))
    else $error("lock came before a full codeword search");
  frame_gap_a: assert property (o_frame_start |-> gap >= 8'd128)
    else $error("frames accepted closer than one search");
  code_hold_a: assert property (!o_frame_start |-> $stable(o_code_idx))
    else $error("codeword index moved without a frame");
  pow_bound_a: assert property (o_corr_pow <= 16'd3249)
    else $error("correlation power above full scale");
  irq_masked_a: assert property (($past(i_wr) && $past(i_addr) == 5'h0c &&
      $past(i_wdata) == 32'h0) |-> ##1 !o_irq)
    else $error("interrupt with an empty mask");

  cover property (o_frame_start);
  cover property ($fell(o_locked));
  cover property (o_irq);
endmodule // fsa_frame_sync_sva

bind fsa_frame_sync fsa_frame_sync_sva u_sva (
  .i_mclk(i_mclk),
  .i_reset_n(i_reset_n),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .o_locked(o_locked),
  .o_frame_start(o_frame_start),
  .o_code_idx(o_code_idx),
  .o_corr_pow(o_corr_pow),
  .o_irq(o_irq)
);

`default_nettype wire

// ### test/fsa_sym_source.sv
// Upstream symbol source: timing-locked QPSK samples, one per valid.
// Assumes the bench selects a steady quadrant or a scrambling walk.
`timescale 1ns/10ps
`default_nettype none

module fsa_sym_source (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Bench control
  input wire logic i_run,
  input wire logic i_mix,
  // Symbol stream
  output logic o_valid,
  output logic signed [7:0] o_i,
  output logic signed [7:0] o_q
);
  logic [1:0] quad;
  logic [1:0] step;
  logic [1:0] shown;

  // Idle cycles show the opposite quadrant, so stale samples never look valid.
  assign shown = o_valid ? quad : quad ^ 2'h2;
  assign o_i = (shown == 2'h1 || shown == 2'h2) ? -8'sd64 : 8'sd64;
  assign o_q = shown[1] ? -8'sd64 : 8'sd64;

  // ==========================================================================
  // The walk steps the phase by 0,1,2,3 quarter turns so no pattern correlates.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_valid <= 1'b0;
      quad <= 2'h0;
      step <= 2'h0;
    end else begin
      o_valid <= i_run;
      if (i_run) begin
        quad <= i_mix ? quad + step : 2'h0;
        step <= step + 2'h1;
      end
    end
  end
endmodule // fsa_sym_source

`default_nettype wire

// ### test/test_frame_sync_acquisition.sv
// Self-checking bench for the frame synchronizer.
// Assumes the default tap parameters: a steady quadrant matches everywhere.
`timescale 1ns/10ps
`default_nettype none

module test_frame_sync_acquisition;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic run = 1'b0;
  logic mix = 1'b0;
  logic sym_valid;
  logic signed [7:0] sym_i, sym_q;
  logic [31:0] o_rdata;
  logic o_locked, o_frame_start, o_irq;
  logic [6:0] o_code_idx;
  logic [15:0] o_corr_pow;
  logic [16:0] frame_len = 17'h00190;
  int failures = 0;
  int comparisons = 0;

  always #50 i_mclk = ~i_mclk;

  fsa_sym_source src (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_run(run), .i_mix(mix),
    .o_valid(sym_valid), .o_i(sym_i), .o_q(sym_q));

  fsa_frame_sync #(.SYM_W(8)) dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_sym_valid(sym_valid), .i_sym_i(sym_i), .i_sym_q(sym_q), .i_frame_len(frame_len),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_locked(o_locked), .o_frame_start(o_frame_start), .o_code_idx(o_code_idx),
    .o_corr_pow(o_corr_pow), .o_irq(o_irq));

  // ==========================================================================
  // Tasks
  task automatic close_out();
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & m, exp);
  endtask

  // Waits for a frame start, or for loss of lock when fs is clear.
  task automatic wait_for(input bit fs, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge i_mclk);
      #1;
      if (fs ? o_frame_start === 1'b1 : o_locked === 1'b0) break;
    end
    if (k == n) begin
      failures++;
      close_out();
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rd(5'h00, 32'hffffffff, 32'h1);
    rd(5'h04, 32'hffffffff, 32'ha65ce19c);
    rd(5'h08, 32'hffffffff, 32'h0);
    rd(5'h0c, 32'hffffffff, 32'h0);
    rd(5'h10, 32'h3, 32'h0);
    wr(5'h04, 32'ha65de19d);
    rd(5'h04, 32'hffffffff, 32'ha65de19d);
    wr(5'h10, 32'hffffffff);
    rd(5'h10, 32'h3, 32'h0);
    wr(5'h14, 32'hffffffff);
    rd(5'h14, 32'hffffffff, 32'h0);
    run <= 1'b1;
    wait_for(1'b1, 300);
    run <= 1'b0;
    chk({31'h0, o_locked}, 32'h1);
    chk({27'h0, o_code_idx[6:2]}, 32'h1);
    chk({16'h0, o_corr_pow}, 32'h00000cb1);
    rd(5'h08, 32'hffffffff, 32'hd);
    rd(5'h10, 32'h0003e007, 32'h00002002);
    chk({31'h0, o_irq}, 32'h0);
    wr(5'h0c, 32'h1);
    repeat (2) @(posedge i_mclk);
    #1 chk({31'h0, o_irq}, 32'h1);
    wr(5'h08, 32'h1);
    repeat (2) @(posedge i_mclk);
    #1 chk({31'h0, o_irq}, 32'h0);
    rd(5'h08, 32'hffffffff, 32'hc);
    frame_len <= 17'h0012c;
    run <= 1'b1;
    wait_for(1'b1, 600);
    chk({31'h0, o_locked}, 32'h1);
    mix <= 1'b1;
    wait_for(1'b0, 200);
    rd(5'h08, 32'h2, 32'h2);
    repeat (300) @(posedge i_mclk);
    #1 chk({31'h0, o_locked}, 32'h0);
    wr(5'h00, 32'h0);
    mix <= 1'b0;
    repeat (300) @(posedge i_mclk);
    #1 chk({31'h0, o_locked}, 32'h0);
    wr(5'h00, 32'h1);
    wait_for(1'b1, 300);
    chk({31'h0, o_locked}, 32'h1);
    wr(5'h0c, 32'h0);
    repeat (3) @(posedge i_mclk);
    #1 chk({31'h0, o_irq}, 32'h0);
    close_out();
  end
endmodule // test_frame_sync_acquisition

`default_nettype wire
